// *** verilog/smpc_regs.vh ***
// Register offsets, field positions, codes and timing constants of the sleep controller.
`ifndef SMPC_REGS_VH
`define SMPC_REGS_VH
`define SMPC_ADDR_SLEEP 4'h0
`define SMPC_ADDR_MCU 4'h1
`define SMPC_ADDR_PWRRED 4'h2
`define SMPC_ADDR_STATUS 4'h3
`define SMPC_BIT_ARM 0
`define SMPC_SEL_LSB 1
`define SMPC_SEL_MSB 3
`define SMPC_BIT_DBGOFF 7
`define SMPC_BIT_BSOFF 6
`define SMPC_BIT_BSUNL 5
`define SMPC_MODE_IDLE 3'h0
`define SMPC_MODE_ADCNR 3'h1
`define SMPC_MODE_PDOWN 3'h2
`define SMPC_MODE_PSAVE 3'h3
`define SMPC_MODE_STBY 3'h6
`define SMPC_UNLOCK_CYC 3'h4
`define SMPC_BSOFF_CYC 3'h3
`define SMPC_STBY_CYC 16'h0006
`define SMPC_BOD_WAKE_US 60
`define SMPC_CLK_MHZ 10
`define SMPC_PRR_MASK 8'h0f
`endif

// *** verilog/smpc_controller.v ***
// Sleep mode and power management controller: clock gating, wake-up, brown-out sleep control.
//
// Overview of operation
// RL1: Detector off in sleep, back on at wake.
// RL2: Wake delay stretched to 60 us if disabled.
// RL3: Bit 6 of control register disables detector.
// RL4: Off control written only through unlock sequence.
// RL5: Software completes second write within four cycles.
// RL6: Active three cycles after set, auto-clears.
// RL7: Sleep needs arm bit plus sleep instruction.
// RL8: Idle stops core and flash clocks only.
// RL9: Idle or noise mode starts ADC conversion.
// RL10: Noise mode also stops io clock.
// RL11: Noise mode wakes on listed sources only.
// RL12: Power-down stops oscillator and generated clocks.
// RL13: Power-down wakes on listed sources only.
// RL14: Power-down wake waits fuse-selected start-up delay.
// RL15: Power-save keeps timer 2, wakes on it.
// RL16: Power-save stops unused timer clock sources.
// RL17: Standby keeps oscillator, wakes in six cycles.
// RL18: Reduction bit stops clock, blocks register access.
// RL19: Clearing reduction bit restarts clock, state kept.
// RL20: ADC stays enabled; re-enable gives extended conversion.
// RL21: Deep sleep disables comparator, reference may stay.
// RL22: Reference enabled only when detector, comparator, ADC.
// RL23: Input buffers off when io and ADC clocks stop.
// RL24: Debug fuse keeps main clock in deep sleep.
// RL25: Scan port disabled by bit or fuse.
// RL26: Reserved sleep code enters no sleep.
`include "smpc_regs.vh"
module smpc_controller #(
    parameter [15:0] STARTUP_CYC = 16'h0400
) (
    // Clock and asynchronous active-low reset.
    input wire ref_clk,
    input wire resetn,
    // Register port; read data stand only in the cycle after the strobe.
    input wire [3:0] regAddr,
    input wire [7:0] regWdata,
    input wire regWrite,
    input wire regRead,
    output reg [7:0] regRdata,
    // Sleep instruction pulse from the core.
    input wire sleepInstr,
    // Static fuse and clock source settings.
    input wire extXtalSelected,
    input wire onchipDebugFuse,
    input wire scanPortFuse,
    input wire bodFuseEnabled,
    // Analog and timer configuration levels.
    input wire adcEnabled,
    input wire comparatorOff,
    input wire comparatorUsesRef,
    input wire timer2Enabled,
    input wire timer2Async,
    // Wake requests from logic on the same clock.
    input wire timer2OvfIrq,
    input wire timer2CmpIrq,
    input wire [1:0] timer2IrqEnables,
    input wire globalIrqEnable,
    input wire wakeAdcDone,
    input wire wakeSpmReady,
    input wire wakeOtherIrq,
    // Wake requests from pins, synchronised inside.
    input wire wakeStartCond,
    input wire wakePinChange,
    input wire extIrqZeroLevel,
    // A reset request wakes every mode.
    input wire wakeResetReq,
    // Clock gates; one means the clock runs.
    output wire coreClockEn,
    output wire flashClockEn,
    output wire ioClockEn,
    output wire adcClockEn,
    output wire asyncClockEn,
    output wire mainOscEn,
    output wire timerOscEn,
    output wire timer2SyncClockEn,
    // Per-peripheral clock and register access gates.
    output wire [3:0] periphClockEn,
    output wire [3:0] periphAccessEn,
    // Conversion controls towards the ADC.
    output reg adcStartConv,
    output reg adcExtendedConv,
    // Analog enables, scan port enable and sleep status.
    output wire comparatorEn,
    output wire vrefEn,
    output wire bodEn,
    output wire inputBufEn,
    output wire scanPortEn,
    output wire sleeping
);
    // Counts for the 60 us detector wake delay; the product is cut to the counter width on purpose.
    localparam integer BOD_WAKE_INT = `SMPC_BOD_WAKE_US * `SMPC_CLK_MHZ;
    localparam [15:0] BOD_WAKE_CYC = BOD_WAKE_INT[15:0];

    // Sequencer states, one-hot. Run executes code; sleep waits for a qualified wake source.
    // Wake counts out the start-up delay with the gates still shut.
    // Resume gives the core one running cycle before another sleep instruction is taken.
    localparam S_RUN = 4'h1;
    localparam S_SLEEP = 4'h2;
    localparam S_WAKE = 4'h4;
    localparam S_RESUME = 4'h8;

    // Sequencer state and its next value.
    reg [3:0] state;
    reg [3:0] next_state;

    // Mode latched at sleep entry, so a later write cannot change a sleep in progress.
    reg [2:0] sleepMode;

    // Sleep control register: arm bit and mode select.
    reg sleepArm;
    reg [2:0] sleepSelect;

    // Debug port disable bit of the control register.
    reg debugPortDisable;

    // Power reduction bits, one per gated peripheral.
    reg [3:0] powerReduction;

    // Detector-off control, its unlock bit and the two timers of the sequence.
    reg brownoutSleepOff;
    reg brownoutSleepUnlock;
    reg [2:0] unlockCnt;
    reg [2:0] bsoffCnt;

    // High while a sleep instruction may still switch the detector off.
    reg bsoffActive;

    // Detector off for the sleep in progress.
    reg bodOffThisSleep;

    // Wake delay counter and its load value.
    reg [15:0] wakeCnt;
    reg [15:0] next_wakeDelay;

    // ADC enable history for the extended conversion flag.
    reg adcEnPrev;
    reg adcOffSeen;

    // Sleep level one cycle back, for the entry edge.
    reg sleepPrev;

    // First and second stages of the pin wake synchroniser.
    reg [2:0] syncA;
    reg [2:0] syncB;

    // Qualified wake request of the present mode.
    reg wakeRaw;

    // Decodes whether a select code names a documented sleep mode.
    function validMode;
        input [2:0] m;
        begin
            validMode = (m == `SMPC_MODE_IDLE) || (m == `SMPC_MODE_ADCNR) || (m == `SMPC_MODE_PDOWN) ||
                        (m == `SMPC_MODE_PSAVE) || (m == `SMPC_MODE_STBY);
        end
    endfunction

    // Deep modes are those that halt the core, flash, io and ADC clocks.
    // Standby counts as deep: only its oscillator and its fixed six-cycle wake delay differ from power-down.
    function deepMode;
        input [2:0] m;
        begin
            deepMode = (m == `SMPC_MODE_PDOWN) || (m == `SMPC_MODE_PSAVE) || (m == `SMPC_MODE_STBY);
        end
    endfunction

    wire asleep = (state == S_SLEEP) || (state == S_WAKE);
    wire inIdle = asleep && (sleepMode == `SMPC_MODE_IDLE);
    wire inNoise = asleep && (sleepMode == `SMPC_MODE_ADCNR);
    wire inDeep = asleep && deepMode(sleepMode);
    wire inSave = asleep && (sleepMode == `SMPC_MODE_PSAVE);
    wire inStby = asleep && (sleepMode == `SMPC_MODE_STBY);
    // Standby is only entered with a crystal or resonator; otherwise the code acts as reserved.
    wire modeOk = validMode(sleepSelect) && ((sleepSelect != `SMPC_MODE_STBY) || extXtalSelected);
    wire goSleep = (state == S_RUN) && sleepInstr && sleepArm && modeOk; // RL7 RL26
    // A sleep instruction with the arm bit clear is simply executed as a no-op.
    wire wrMcu = regWrite && (regAddr == `SMPC_ADDR_MCU);
    // Timer 2 wakes only with its own enable and the global enable both set.
    wire timer2Wake = timer2Enabled && globalIrqEnable &&
                      ((timer2OvfIrq && timer2IrqEnables[0]) || (timer2CmpIrq && timer2IrqEnables[1]));

    // Pin-side wake sources cross into the clock domain through three stages; a change counts on agreement.
    always @(posedge ref_clk or negedge resetn) begin
        if (!resetn) begin
            syncA <= 3'h0;
            syncB <= 3'h0;
        end else begin
            // Only the second stage reads the first, so a metastable first stage never fans out.
            syncA <= {wakeStartCond, wakePinChange, extIrqZeroLevel};
            syncB <= syncA;
        end
    end

    // Third stage and agreement test kept separate so only the second stage reads the first.
    reg [2:0] syncC;
    always @(posedge ref_clk or negedge resetn) begin
        if (!resetn) syncC <= 3'h0;
        else syncC <= syncB;
    end
    wire [2:0] pinWake = syncB & syncC;

    // Per-mode wake qualification.
    // A level on the external interrupt must be held until the synchroniser agrees, or it is lost.
    always @* begin
        wakeRaw = wakeResetReq | (|pinWake);
        if (inIdle) begin
            wakeRaw = wakeRaw | wakeAdcDone | wakeSpmReady | wakeOtherIrq | timer2Wake;
        end else if (inNoise) begin
            wakeRaw = wakeRaw | wakeAdcDone | wakeSpmReady | (timer2Wake && timer2Async); // RL11
        end else if (inSave) begin
            wakeRaw = wakeRaw | timer2Wake; // RL15
        end else begin
            wakeRaw = wakeRaw; // RL13
        end
    end

    // Wake delay: standby is fixed, deep modes use the fuse start-up time, detector-off sleeps stretch it.
    // The detector needs its full settle time whatever the mode, so the longer count wins.
    // The cost is a slow wake-up from every detector-off sleep, even a short one.
    always @* begin
        if (inStby) next_wakeDelay = `SMPC_STBY_CYC; // RL17
        else if (inDeep) next_wakeDelay = STARTUP_CYC; // RL14
        else next_wakeDelay = 16'h0001;
        if (bodOffThisSleep && next_wakeDelay < BOD_WAKE_CYC) next_wakeDelay = BOD_WAKE_CYC; // RL2
    end

    // Sleep sequencer.
    // A wake source that drops during the delay does not cancel the wake-up.
    // Unused one-hot codes fall back to run, so a disturbed state never locks the clocks off.
    always @* begin
        case (state)
            S_RUN: next_state = goSleep ? S_SLEEP : S_RUN;
            S_SLEEP: next_state = wakeRaw ? S_WAKE : S_SLEEP;
            S_WAKE: next_state = (wakeCnt <= 16'h0001) ? S_RESUME : S_WAKE;
            S_RESUME: next_state = S_RUN;
            default: next_state = S_RUN;
        endcase
    end

    always @(posedge ref_clk or negedge resetn) begin
        if (!resetn) begin
            state <= S_RUN;
            sleepMode <= 3'h0;
            wakeCnt <= 16'h0000;
            bodOffThisSleep <= 1'b0;
        end else begin
            state <= next_state;
            if (goSleep) begin
                sleepMode <= sleepSelect;
                bodOffThisSleep <= bsoffActive && deepMode(sleepSelect); // RL1 RL6
            end
            if (state == S_SLEEP && wakeRaw) wakeCnt <= next_wakeDelay;
            else if (state == S_WAKE) wakeCnt <= wakeCnt - 16'h0001;
            if (state == S_RESUME) bodOffThisSleep <= 1'b0; // RL1
        end
    end

    // Control registers and the timed brown-out sleep unlock.
    always @(posedge ref_clk or negedge resetn) begin
        if (!resetn) begin
            sleepArm <= 1'b0;
            sleepSelect <= 3'h0;
            debugPortDisable <= 1'b0;
            powerReduction <= 4'h0;
            brownoutSleepOff <= 1'b0; // RL3
            brownoutSleepUnlock <= 1'b0;
            unlockCnt <= 3'h0;
            bsoffCnt <= 3'h0;
            bsoffActive <= 1'b0;
        end else begin
            if (regWrite && regAddr == `SMPC_ADDR_SLEEP) begin
                sleepArm <= regWdata[`SMPC_BIT_ARM];
                sleepSelect <= regWdata[`SMPC_SEL_MSB:`SMPC_SEL_LSB];
            end
            if (regWrite && regAddr == `SMPC_ADDR_PWRRED) begin
                powerReduction <= regWdata[3:0]; // RL18 RL19
            end
            if (wrMcu) debugPortDisable <= regWdata[`SMPC_BIT_DBGOFF];
            // The unlock window closes four cycles after the first write; a new unlock write restarts it.
            // An off-bit write outside the window leaves the bit untouched, as any stray write must.
            if (unlockCnt != 3'h0) unlockCnt <= unlockCnt - 3'h1;
            if (wrMcu && regWdata[`SMPC_BIT_BSOFF] && regWdata[`SMPC_BIT_BSUNL]) begin
                brownoutSleepUnlock <= 1'b1;
                unlockCnt <= `SMPC_UNLOCK_CYC; // RL4 RL5
            end else if (wrMcu && brownoutSleepUnlock && unlockCnt != 3'h0 && regWdata[`SMPC_BIT_BSOFF]) begin
                brownoutSleepOff <= 1'b1; // RL4
                brownoutSleepUnlock <= 1'b0;
                unlockCnt <= 3'h0;
                bsoffCnt <= `SMPC_BSOFF_CYC + `SMPC_BSOFF_CYC;
            end else if (unlockCnt == 3'h1) begin
                brownoutSleepUnlock <= 1'b0;
            end
            // Becomes active after three cycles, then holds for three more before clearing itself.
            if (bsoffCnt != 3'h0) begin
                bsoffCnt <= bsoffCnt - 3'h1;
                bsoffActive <= (bsoffCnt <= `SMPC_BSOFF_CYC + 3'h1) && (bsoffCnt > 3'h1); // RL6
                if (bsoffCnt == 3'h1) brownoutSleepOff <= 1'b0; // RL6
            end else begin
                bsoffActive <= 1'b0;
            end
        end
    end

    // ADC start on idle/noise entry and extended conversion after an off/on cycle.
    // Reset counts as the ADC having been off, so the first conversion is always extended.
    always @(posedge ref_clk or negedge resetn) begin
        if (!resetn) begin
            adcStartConv <= 1'b0;
            adcExtendedConv <= 1'b0;
            adcEnPrev <= 1'b0;
            adcOffSeen <= 1'b1;
            sleepPrev <= 1'b0;
        end else begin
            sleepPrev <= asleep;
            adcEnPrev <= adcEnabled;
            adcStartConv <= adcEnabled && asleep && !sleepPrev &&
                            (sleepMode == `SMPC_MODE_IDLE || sleepMode == `SMPC_MODE_ADCNR); // RL9
            if (!adcEnabled) adcOffSeen <= 1'b1;
            else if (adcEnabled && !adcEnPrev) adcExtendedConv <= adcOffSeen; // RL20
            if (adcEnabled && adcEnPrev && wakeAdcDone) begin
                adcOffSeen <= 1'b0;
                adcExtendedConv <= 1'b0;
            end
        end
    end

    // Clock gating per mode.
    // Standby keeps the oscillator but no generated clock.
    // A debug session keeps the main clock in power-down and power-save so the debugger stays in step.
    wire debugHold = onchipDebugFuse && asleep &&
                     (sleepMode == `SMPC_MODE_PDOWN || sleepMode == `SMPC_MODE_PSAVE); // RL24
    assign coreClockEn = !asleep; // RL8
    assign flashClockEn = !asleep; // RL8
    assign ioClockEn = !asleep || inIdle; // RL10
    assign adcClockEn = !asleep || inIdle || inNoise; // RL10
    assign asyncClockEn = !inDeep || (inSave && timer2Enabled && timer2Async); // RL12 RL15
    assign mainOscEn = !inDeep || inStby || debugHold ||
                       (inSave && timer2Enabled && !timer2Async); // RL12 RL16 RL17 RL24
    assign timerOscEn = !inDeep || (inSave && timer2Enabled && timer2Async); // RL16
    assign timer2SyncClockEn = mainOscEn && !(inDeep && !inSave) && !inStby; // RL16
    assign periphClockEn = ioClockEn ? ~powerReduction : 4'h0; // RL18 RL19
    assign periphAccessEn = ~powerReduction; // RL18
    assign comparatorEn = !comparatorOff && !inDeep; // RL21
    assign bodEn = bodFuseEnabled && !bodOffThisSleep; // RL1
    assign vrefEn = bodEn || adcEnabled || (!comparatorOff && (comparatorEn || comparatorUsesRef)); // RL21 RL22
    assign inputBufEn = ioClockEn || adcClockEn; // RL23
    assign scanPortEn = scanPortFuse && !debugPortDisable; // RL25
    assign sleeping = asleep;

    // Register read port; data stand in the cycle after the read strobe.
    // Unmapped offsets and idle cycles read zero rather than holding the last value.
    always @(posedge ref_clk or negedge resetn) begin
        if (!resetn) regRdata <= 8'h00;
        else if (regRead) begin
            case (regAddr)
                `SMPC_ADDR_SLEEP: regRdata <= {4'h0, sleepSelect, sleepArm};
                `SMPC_ADDR_MCU: regRdata <= {debugPortDisable, brownoutSleepOff, brownoutSleepUnlock, 5'h00};
                `SMPC_ADDR_PWRRED: regRdata <= {4'h0, powerReduction} & `SMPC_PRR_MASK;
                `SMPC_ADDR_STATUS: regRdata <= {4'h0, state};
                default: regRdata <= 8'h00;
            endcase
        end else regRdata <= 8'h00;
    end
endmodule

// *** verif/smpc_chk.sv ***
// Concurrent checks on the sleep controller's ports, bound to its top module.
module smpc_chk (
    input wire ref_clk,
    input wire resetn,
    input wire sleepInstr,
    input wire adcEnabled,
    input wire comparatorUsesRef,
    input wire onchipDebugFuse,
    input wire scanPortFuse,
    input wire bodFuseEnabled,
    input wire coreClockEn,
    input wire flashClockEn,
    input wire ioClockEn,
    input wire adcClockEn,
    input wire mainOscEn,
    input wire [3:0] periphClockEn,
    input wire [3:0] periphAccessEn,
    input wire adcStartConv,
    input wire comparatorEn,
    input wire vrefEn,
    input wire bodEn,
    input wire inputBufEn,
    input wire scanPortEn,
    input wire sleeping
);
    timeunit 1ns;
    timeprecision 1ns;
    // One clock domain, so every check shares the clock and rests during reset.
    default clocking cb @(posedge ref_clk);
    endclocking
    default disable iff (!resetn);
    sleep_needs_instr_a: assert property ($rose(sleeping) |-> $past(sleepInstr))
        else $error("sleep entered without a sleep instruction");
    core_halted_a: assert property ($rose(sleeping) |-> (!coreClockEn && !flashClockEn) [*2])
        else $error("core or flash clock running in sleep");
    adc_autostart_a: assert property ($rose(sleeping) && adcClockEn && adcEnabled |-> ##[0:1] adcStartConv)
        else $error("no conversion start on sleep entry");
    inbuf_off_a: assert property (!ioClockEn && !adcClockEn |-> !inputBufEn)
        else $error("input buffers on with io and adc clocks stopped");
    comp_deep_off_a: assert property (sleeping && !ioClockEn && !adcClockEn |-> !comparatorEn)
        else $error("comparator left on in deep sleep");
    vref_need_a: assert property (vrefEn |-> bodEn || comparatorEn || adcEnabled || comparatorUsesRef)
        else $error("reference on with no user");
    scan_fuse_a: assert property (!scanPortFuse |-> !scanPortEn)
        else $error("scan port on with fuse unprogrammed");
    periph_pair_a: assert property (periphClockEn == (ioClockEn ? periphAccessEn : 4'h0))
        else $error("peripheral clock and access gates disagree");
    debug_osc_a: assert property ($rose(sleeping) && onchipDebugFuse |=> mainOscEn)
        else $error("main oscillator stopped with debug fuse set");
    bod_drop_a: assert property ($fell(bodEn) && bodFuseEnabled |-> sleeping)
        else $error("detector switched off outside sleep");
    // Main scenarios that the bench should reach.
    cover property ($rose(sleeping) && !ioClockEn);
    cover property ($fell(bodEn));
    cover property (adcStartConv);
endmodule
bind smpc_controller smpc_chk i_chk (.ref_clk(ref_clk), .resetn(resetn), .sleepInstr(sleepInstr),
    .adcEnabled(adcEnabled), .comparatorUsesRef(comparatorUsesRef), .onchipDebugFuse(onchipDebugFuse),
    .scanPortFuse(scanPortFuse), .bodFuseEnabled(bodFuseEnabled), .coreClockEn(coreClockEn),
    .flashClockEn(flashClockEn), .ioClockEn(ioClockEn),
    .adcClockEn(adcClockEn), .mainOscEn(mainOscEn), .periphClockEn(periphClockEn),
    .periphAccessEn(periphAccessEn), .adcStartConv(adcStartConv), .comparatorEn(comparatorEn), .vrefEn(vrefEn),
    .bodEn(bodEn), .inputBufEn(inputBufEn), .scanPortEn(scanPortEn), .sleeping(sleeping));

// *** verif/smpc_core_model.sv ***
// Behavioural model of the core and the wake-up sources facing the sleep controller.
module smpc_core_model (
    input wire ref_clk,
    input wire resetn,
    input wire issue,
    input wire [1:0] wakeSel,
    input wire sleeping,
    output logic sleepInstr,
    output logic [3:0] wakeLines
);
    timeunit 1ns;
    timeprecision 1ns;
    logic [3:0] sleepAge;
    // The core pulses its sleep instruction a cycle after being asked; a wake source holds its
    // request until the controller is awake, because a level interrupt must be held to count.
    always @(posedge ref_clk or negedge resetn) begin
        if (!resetn) begin
            sleepInstr <= 1'b0;
            wakeLines <= 4'h0;
            sleepAge <= 4'h0;
        end else begin
            sleepInstr <= issue;
            sleepAge <= sleeping ? sleepAge + {3'h0, sleepAge != 4'hf} : 4'h0;
            wakeLines <= (sleeping && sleepAge > 4'h3) ? 4'h1 << wakeSel : 4'h0;
        end
    end
endmodule

// *** verif/tb_top.sv ***
// Self-checking bench for the sleep controller: registers, sleep modes and detector-off sleep.
module tb_top;
    timeunit 1ns;
    timeprecision 1ns;
    logic clk, resetn, regWrite, regRead, issue, xtal, dbg, scanFuse, bodFuse, adcEn, cmpOff, cmpRef;
    logic t2En, t2Async, gie, sleepInstr, coreEn, flashEn, ioEn, adcClkEn, oscEn, sleeping, bodEn, scanEn;
    logic [1:0] t2Ie, wakeSel;
    logic [3:0] regAddr, wakeLines, pClk, pAcc;
    logic adcDone, otherIrq;
    logic [7:0] regWdata, regRdata, rdv, snap, mask;
    logic [2:0] mode;
    integer seed = 73;
    integer n_fail = 0;
    integer check_count = 0;
    integer i, t, dur;
    smpc_controller #(.STARTUP_CYC(16'h0008)) i_dut (.ref_clk(clk), .resetn(resetn), .regAddr(regAddr),
        .regWdata(regWdata), .regWrite(regWrite), .regRead(regRead), .regRdata(regRdata), .sleepInstr(sleepInstr),
        .extXtalSelected(xtal), .onchipDebugFuse(dbg), .scanPortFuse(scanFuse), .bodFuseEnabled(bodFuse),
        .adcEnabled(adcEn), .comparatorOff(cmpOff), .comparatorUsesRef(cmpRef), .timer2Enabled(t2En),
        .timer2Async(t2Async), .timer2OvfIrq(1'b0), .timer2CmpIrq(1'b0), .timer2IrqEnables(t2Ie),
        .globalIrqEnable(gie), .wakeAdcDone(adcDone), .wakeSpmReady(1'b0), .wakeOtherIrq(otherIrq),
        .wakeStartCond(wakeLines[1]), .wakePinChange(wakeLines[0]), .extIrqZeroLevel(wakeLines[2]),
        .wakeResetReq(wakeLines[3]), .coreClockEn(coreEn), .flashClockEn(flashEn), .ioClockEn(ioEn),
        .adcClockEn(adcClkEn), .asyncClockEn(), .mainOscEn(oscEn), .timerOscEn(), .timer2SyncClockEn(),
        .periphClockEn(pClk), .periphAccessEn(pAcc), .adcStartConv(), .adcExtendedConv(), .comparatorEn(),
        .vrefEn(), .bodEn(bodEn), .inputBufEn(), .scanPortEn(scanEn), .sleeping(sleeping));
    smpc_core_model i_core (.ref_clk(clk), .resetn(resetn), .issue(issue), .wakeSel(wakeSel),
        .sleeping(sleeping), .sleepInstr(sleepInstr), .wakeLines(wakeLines));

    // Free-running 10 MHz clock.
    initial begin
        clk = 1'b0;
        forever #50 clk = ~clk;
    end

    // Snapshot {0, bodEn, sleeping, core, flash, io, adc, osc} that a sleep attempt must show.
    function automatic logic [7:0] expSnap(input logic [2:0] m, input logic arm, xt, dbgF, bodF);
        expSnap = {1'b0, bodF, 6'h1f};
        if (arm) begin
            case (m)
                3'h0: expSnap = {1'b0, bodF, 6'h27};
                3'h1: expSnap = {1'b0, bodF, 6'h23};
                3'h2: expSnap = {1'b0, bodF, 5'h10, dbgF};
                3'h3: expSnap = {1'b0, bodF, 6'h20};
                3'h6: if (xt) expSnap = {1'b0, bodF, 6'h21};
                default: expSnap = {1'b0, bodF, 6'h1f};
            endcase
        end
    endfunction

    // Value compare; a mismatch is reported at once.
    task automatic chk(input string what, input logic [7:0] exp, input logic [7:0] got);
        check_count++;
        if (got !== exp) begin
            n_fail++;
            $display("ERROR %s expected %h seen %h", what, exp, got);
        end
    endtask

    // Duration compare against an inclusive window of cycles.
    task automatic chkSpan(input string what, input integer lo, input integer hi, input integer got);
        check_count++;
        if (got < lo || got > hi) begin
            n_fail++;
            $display("ERROR %s expected %0d..%0d seen %0d", what, lo, hi, got);
        end
    endtask

    // One-cycle write; an idle cycle follows so the strobe is never re-raised in the same step.
    task automatic wr(input logic [3:0] a, input logic [7:0] d);
        regAddr <= a;
        regWdata <= d;
        regWrite <= 1'b1;
        @(posedge clk);
        regWrite <= 1'b0;
        @(posedge clk);
    endtask

    // One-cycle read; data is taken in the following cycle, its only valid one.
    task automatic rd(input logic [3:0] a, output logic [7:0] d);
        regAddr <= a;
        regRead <= 1'b1;
        @(posedge clk);
        regRead <= 1'b0;
        #1 d = regRdata;
        @(posedge clk);
    endtask

    // Ask the core to sleep, snapshot the gates once asleep, then time the stay.
    task automatic sleepRun(output logic [7:0] s, output integer d);
        issue <= 1'b1;
        @(posedge clk);
        issue <= 1'b0;
        repeat (2) @(posedge clk);
        #1 s = {1'b0, bodEn, sleeping, coreEn, flashEn, ioEn, adcClkEn, oscEn};
        d = 0;
        while (sleeping === 1'b1 && d < 3000) begin
            @(posedge clk);
            d++;
        end
        repeat (8) @(posedge clk);
    endtask

    task automatic report_and_stop;
        $display("checks %0d mismatches %0d", check_count, n_fail);
        if (n_fail == 0 && check_count > 0)
            $display("Result: passed");
        else
            $display("Result: failed");
        $finish;
    endtask

    // Cuts a hang short at 20000 cycles, well beyond the roughly 1100 cycles the tests need.
    initial begin
        #2000000;
        n_fail++;
        report_and_stop;
    end

    // Main sequence.
    initial begin
        {resetn, regWrite, regRead, issue, regAddr, regWdata, dbg, adcEn, cmpOff, cmpRef, gie, t2Ie} = 0;
        {adcDone, otherIrq} = 2'b00;
        {xtal, scanFuse, bodFuse, t2En, t2Async} = 5'h1f;
        wakeSel = 2'h0;
        repeat (3) @(posedge clk);
        resetn <= 1'b1;
        @(posedge clk);
        for (i = 0; i < 5; i++) begin
            rd(i == 4 ? 4'hf : i[3:0], rdv);
            chk("reset read", i == 3 ? 8'h01 : 8'h00, rdv);
        end
        $display("test reset values done");
        for (i = 0; i < 6; i++) begin
            t = $random(seed);
            wr(4'h2, t[7:0]);
            rd(4'h2, rdv);
            chk("reduction read", t[7:0] & 8'h0f, rdv);
            chk("peripheral clocks", {4'h0, ~t[3:0]}, {4'h0, pClk});
            chk("peripheral access", {4'h0, ~t[3:0]}, {4'h0, pAcc});
        end
        wr(4'h1, 8'h80);
        chk("scan port off", 8'h00, {7'h00, scanEn});
        wr(4'h1, 8'h00);
        chk("scan port on", 8'h01, {7'h00, scanEn});
        scanFuse <= 1'b0;
        @(posedge clk);
        chk("scan fuse off", 8'h00, {7'h00, scanEn});
        scanFuse <= 1'b1;
        $display("test reduction and scan done");
        for (i = 0; i < 14; i++) begin
            t = $random(seed);
            mode = i < 8 ? i[2:0] : t[2:0];
            {dbg, adcEn, cmpOff, cmpRef, t2Async, gie, t2Ie, wakeSel, bodFuse, t2En} <= t[15:4];
            xtal <= i < 8 ? 1'b1 : t[3];
            wr(4'h0, {4'h0, mode, i != 9});
            sleepRun(snap, dur);
            mask = mode == 3'h3 ? 8'h7e : 8'h7f;
            chk("sleep gates", expSnap(mode, i != 9, xtal, dbg, bodFuse) & mask, snap & mask);
            chkSpan("plain wake span", 0, 599, dur);
        end
        $display("test sleep modes done");
        {bodFuse, dbg, xtal} <= 3'h5;
        wr(4'h0, 8'h05);
        for (i = 0; i < 3; i++) begin
            if (i != 1) wr(4'h1, 8'h60);
            wr(4'h1, 8'h40);
            repeat (i == 2 ? 10 : 1) @(posedge clk);
            sleepRun(snap, dur);
            chk("detector in sleep", {7'h00, i != 0}, {7'h00, snap[6]});
            chkSpan("detector wake span", i == 0 ? 595 : 0, i == 0 ? 3000 : 599, dur);
            chk("detector after wake", 8'h01, {7'h00, bodEn});
        end
        $display("test detector sleep done");
        report_and_stop;
    end
endmodule
